/* design/level_loop.sv */
// level loop: automatic input amplifier gain control with limiter mode
// assumes samples and register writes come from logic on sys_clk
`timescale 1ns/100ps
`default_nettype none
module level_loop #(
  parameter int unsigned ATK_NORM_CYC = level_loop_pkg::ATK_NORM_NS
    * level_loop_pkg::CLK_MHZ / level_loop_pkg::NS_PER_US,
  parameter int unsigned DCY_NORM_CYC = level_loop_pkg::DCY_NORM_NS
    * level_loop_pkg::CLK_MHZ / level_loop_pkg::NS_PER_US,
  parameter int unsigned ATK_LIM_CYC = level_loop_pkg::ATK_LIM_NS
    * level_loop_pkg::CLK_MHZ / level_loop_pkg::NS_PER_US,
  parameter int unsigned DCY_LIM_CYC = level_loop_pkg::DCY_LIM_NS
    * level_loop_pkg::CLK_MHZ / level_loop_pkg::NS_PER_US,
  parameter int unsigned HOLD_CYC = level_loop_pkg::HOLD_NS
    * level_loop_pkg::CLK_MHZ / level_loop_pkg::NS_PER_US
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire level_loop_pkg::reg_wr_s reg_wr,
  input wire logic [level_loop_pkg::ADDR_W-1:0] rd_addr,
  output logic [level_loop_pkg::REG_W-1:0] reg_rdata,
  input wire level_loop_pkg::sample_s sample,
  input wire logic manual_gain_load,
  input wire logic [level_loop_pkg::GAIN_W-1:0] manual_input_gain,
  output logic [level_loop_pkg::GAIN_W-1:0] amp_gain,
  output logic gain_step,
  output logic loop_active
);
  import level_loop_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  limits_s cfg_limits;               // enable and gain limits
  target_s cfg_target;               // target level and hold
  rates_s cfg_rates;                 // mode and step rates
  logic zero_cross_gate;             // wait for zero crossing
  loop_e state;                      // loop state
  loop_e next_state;
  logic [GAIN_W-1:0] start_gain;     // limiter rise cap
  logic [SAMPLE_W-1:0] abs_now;      // magnitude of current sample
  logic [SAMPLE_W-1:0] peak;         // running peak since last step
  logic over;                        // peak above target
  logic step_tick;                   // one step interval done
  logic hold_tick;                   // hold interval done
  logic hold_ok;                     // increases allowed
  logic last_sign;                   // sign of previous sample
  logic zc_seen;                     // crossing on this sample
  logic pend_up;                     // step waiting to apply
  logic pend_dn;
  logic apply;                       // apply pending step now
  logic want_up;
  logic want_dn;
  logic [GAIN_W-1:0] floor_code;
  logic [GAIN_W-1:0] ceil_code;
  logic [GAIN_W-1:0] up_lim;         // highest gain a rise may reach
  logic [CNT_W-1:0] step_period;
  logic [CNT_W-1:0] hold_period;
  logic [3:0] hold_shift;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // reserved bits are forced to zero so they read back as zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_limits <= LIMITS_RST;
      cfg_target <= TARGET_RST;
      cfg_rates <= RATES_RST;
      zero_cross_gate <= ZC_RST;
    end else if (reg_wr.wr) begin
      unique case (reg_wr.addr)
        OFS_ENABLE_LIMITS: begin
          cfg_limits <= limits_s'(reg_wr.data);
          cfg_limits.rsvd <= '0;
        end
        OFS_TARGET_HOLD: begin
          cfg_target <= target_s'(reg_wr.data);
          cfg_target.rsvd <= 1'b0;
        end
        OFS_MODE_RATES: cfg_rates <= rates_s'(reg_wr.data);
        OFS_ZERO_CROSS: zero_cross_gate <= reg_wr.data[1];
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // ----------------------------------------
  // register reads, registered
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      unique case (rd_addr)
        OFS_ENABLE_LIMITS: reg_rdata <= cfg_limits;
        OFS_TARGET_HOLD: reg_rdata <= cfg_target;
        OFS_MODE_RATES: reg_rdata <= cfg_rates;
        OFS_ZERO_CROSS: reg_rdata <= {7'h00, zero_cross_gate, 1'b0};
        default: reg_rdata <= '0; // unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------
  // loop state
  // ----------------------------------------
  always_comb begin
    if (!cfg_limits.level_loop_enable) begin
      next_state = LOOP_OFF;
    end else if (cfg_rates.limiter_mode_select) begin
      next_state = LOOP_LIMIT;
    end else begin
      next_state = LOOP_TRACK;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= LOOP_OFF;
      loop_active <= 1'b0;
    end else begin
      state <= next_state;
      loop_active <= (next_state != LOOP_OFF);
    end
  end

  // starting gain caught on limiter entry, from off or from tracking
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_gain <= GAIN_RST;
    end else if (next_state == LOOP_LIMIT && state != LOOP_LIMIT) begin
      start_gain <= amp_gain;
    end
  end

  // ----------------------------------------
  // peak detector
  // ----------------------------------------
  // -32768 maps to 8000, which still fits the unsigned magnitude
  assign abs_now = sample.data[SAMPLE_W-1] ? SAMPLE_W'(-sample.data) : sample.data;
  assign over = peak > TARGET_TBL[cfg_target.target_level];

  // peak restarts each step so a decision reflects only that interval
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      peak <= '0;
    end else if (step_tick || state == LOOP_OFF) begin
      peak <= sample.valid ? abs_now : '0;
    end else if (sample.valid && abs_now > peak) begin
      peak <= abs_now;
    end
  end

  // ----------------------------------------
  // step and hold timing
  // ----------------------------------------
  always_comb begin
    if (over) begin
      step_period = CNT_W'(cfg_rates.limiter_mode_select ? ATK_LIM_CYC : ATK_NORM_CYC)
        << sat_code(cfg_rates.gain_fall_rate, RATE_SAT);
    end else begin
      step_period = CNT_W'(cfg_rates.limiter_mode_select ? DCY_LIM_CYC : DCY_NORM_CYC)
        << sat_code(cfg_rates.gain_rise_rate, RATE_SAT);
    end
  end

  // code 1 is one base hold, each code above doubles it up to code 10
  assign hold_shift = sat_code(cfg_target.hold_delay, HOLD_SAT) - 4'h1;
  assign hold_period = CNT_W'(HOLD_CYC) << hold_shift;

  step_timer #(.CNT_W(CNT_W)) u_step_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .restart(state == LOOP_OFF),
    .period(step_period),
    .tick(step_tick)
  );

  step_timer #(.CNT_W(CNT_W)) u_hold_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .restart(state == LOOP_OFF || over || hold_ok),
    .period(hold_period),
    .tick(hold_tick)
  );

  // hold restarts whenever the signal goes over target
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_ok <= 1'b0;
    end else if (state == LOOP_OFF || over) begin
      hold_ok <= 1'b0;
    end else if (cfg_target.hold_delay == 4'h0 || hold_tick) begin
      hold_ok <= 1'b1;
    end
  end

  // ----------------------------------------
  // step decision
  // ----------------------------------------
  assign floor_code = {cfg_limits.gain_floor, FLOOR_FRAC};
  assign ceil_code = {cfg_limits.gain_ceiling, CEIL_FRAC};
  assign up_lim = (state == LOOP_LIMIT && start_gain < ceil_code) ? start_gain : ceil_code;
  assign want_dn = amp_gain > ceil_code || (over && amp_gain > floor_code);
  assign want_up = !want_dn
    && (amp_gain < floor_code || (!over && hold_ok && amp_gain < up_lim));

  // ----------------------------------------
  // zero cross gate
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_sign <= 1'b0;
    end else if (sample.valid) begin
      last_sign <= sample.data[SAMPLE_W-1];
    end
  end

  assign zc_seen = sample.valid && (sample.data[SAMPLE_W-1] != last_sign);
  assign apply = (pend_up || pend_dn) && (!zero_cross_gate || zc_seen);

  // a later decision replaces one still waiting for its crossing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_up <= 1'b0;
      pend_dn <= 1'b0;
    end else if (state == LOOP_OFF) begin
      pend_up <= 1'b0;
      pend_dn <= 1'b0;
    end else if (step_tick) begin
      pend_up <= want_up;
      pend_dn <= want_dn;
    end else if (apply) begin
      pend_up <= 1'b0;
      pend_dn <= 1'b0;
    end
  end

  // ----------------------------------------
  // amplifier gain
  // ----------------------------------------
  // limits are not applied to manual loads while the loop is off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      amp_gain <= GAIN_RST;
      gain_step <= 1'b0;
    end else if (state == LOOP_OFF) begin
      gain_step <= 1'b0;
      if (manual_gain_load) begin
        amp_gain <= manual_input_gain;
      end
    end else begin
      gain_step <= apply;
      if (apply && pend_up) begin
        amp_gain <= amp_gain + GAIN_W'(1);
      end else if (apply) begin
        amp_gain <= amp_gain - GAIN_W'(1);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_enter_limit;
    state != LOOP_LIMIT ##1 state == LOOP_LIMIT;
  endsequence

  sequence s_limit_rise;
    state == LOOP_LIMIT ##1 (state == LOOP_LIMIT && amp_gain > $past(amp_gain));
  endsequence

  a_off_holds_gain: assert property (
    (state == LOOP_OFF && !manual_gain_load) |=> $stable(amp_gain))
    else $error("gain moved while loop off");
  // compares against the enable bit itself, not against the state it drives
  a_enable_state: assert property (
    (cfg_limits.level_loop_enable != loop_active)
      |=> loop_active == $past(cfg_limits.level_loop_enable))
    else $error("loop state does not follow enable");
  a_mode_select: assert property (
    (cfg_limits.level_loop_enable && cfg_rates.limiter_mode_select) |=> state == LOOP_LIMIT)
    else $error("limiter mode not entered");
  a_limit_start: assert property (
    s_enter_limit |-> start_gain == $past(amp_gain))
    else $error("limiter start gain not captured");
  a_limit_no_rise: assert property (
    s_limit_rise |-> amp_gain <= start_gain || amp_gain <= floor_code)
    else $error("limiter raised gain above start");
  a_fall_on_over: assert property (
    (step_tick && state != LOOP_OFF && over && amp_gain > floor_code) |=> pend_dn && !pend_up)
    else $error("no fall decision above target");
  a_rise_below: assert property (
    (step_tick && state != LOOP_OFF && !over && hold_ok && amp_gain <= ceil_code
      && amp_gain < up_lim) |=> pend_up && !pend_dn)
    else $error("no rise decision below target");
  a_ceil_lowers: assert property (
    (step_tick && state != LOOP_OFF && amp_gain > ceil_code) |=> pend_dn && !pend_up)
    else $error("gain over ceiling not lowered");
  // gain_step rises with the new gain, so it is read in the same cycle
  a_gain_single: assert property (
    (state != LOOP_OFF && $past(state) != LOOP_OFF && amp_gain != $past(amp_gain))
      |-> (amp_gain - $past(amp_gain) == 6'h01 || $past(amp_gain) - amp_gain == 6'h01)
      && gain_step && $past(apply))
    else $error("gain moved by more than one step");
  a_zc_waits: assert property (
    (state != LOOP_OFF && zero_cross_gate && !zc_seen && !manual_gain_load) |=> $stable(amp_gain))
    else $error("gain changed without a zero crossing");
  a_peak_track: assert property (
    (sample.valid && abs_now > peak && !step_tick && state != LOOP_OFF) |=> peak == $past(abs_now))
    else $error("peak detector missed a larger sample");

endmodule : level_loop
`default_nettype wire

/* shared/level_loop_pkg.sv */
// level loop package: register map, field layouts, reset values, step timing
// assumes a single 100 MHz sys_clk shared by every file that imports it
package level_loop_pkg;

  // ----------------------------------------
  // clock and widths
  // ----------------------------------------
  localparam int CLK_MHZ = 100;       // sys_clk rate
  localparam int NS_PER_US = 1000;    // unit scaling for time constants
  localparam int ADDR_W = 7;          // register index width
  localparam int REG_W = 9;           // register data width
  localparam int GAIN_W = 6;          // amplifier gain code, 0.75 dB per code
  localparam int SAMPLE_W = 16;       // converter sample width
  localparam int CNT_W = 32;          // step timer width

  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ENABLE_LIMITS = 7'h20;
  localparam logic [ADDR_W-1:0] OFS_TARGET_HOLD = 7'h21;
  localparam logic [ADDR_W-1:0] OFS_MODE_RATES = 7'h22;
  localparam logic [ADDR_W-1:0] OFS_ZERO_CROSS = 7'h2A;

  // ----------------------------------------
  // register layouts, msb first
  // ----------------------------------------
  typedef struct packed {
    logic level_loop_enable;          // bit 8
    logic [1:0] rsvd;                 // reads zero
    logic [2:0] gain_ceiling;         // bits 5:3
    logic [2:0] gain_floor;           // bits 2:0
  } limits_s;
  typedef struct packed {
    logic rsvd;                       // reads zero
    logic [3:0] hold_delay;           // bits 7:4
    logic [3:0] target_level;         // bits 3:0
  } target_s;
  typedef struct packed {
    logic limiter_mode_select;        // bit 8
    logic [3:0] gain_rise_rate;       // bits 7:4
    logic [3:0] gain_fall_rate;       // bits 3:0
  } rates_s;
  typedef struct packed {
    logic wr;                         // one-cycle write strobe
    logic [ADDR_W-1:0] addr;          // register index
    logic [REG_W-1:0] data;           // write data
  } reg_wr_s;
  typedef struct packed {
    logic valid;                      // one-cycle sample strobe
    logic signed [SAMPLE_W-1:0] data; // two's complement sample
  } sample_s;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam limits_s LIMITS_RST = '{1'b0, 2'h0, 3'h7, 3'h0};
  localparam target_s TARGET_RST = '{1'b0, 4'h0, 4'hB};
  localparam rates_s RATES_RST = '{1'b0, 4'h3, 4'h2};
  localparam logic ZC_RST = 1'b0;
  localparam logic [GAIN_W-1:0] GAIN_RST = 6'h10;   // 0 dB
  localparam logic [2:0] CEIL_FRAC = 3'h7;          // ceiling sits 7 codes up
  localparam logic [2:0] FLOOR_FRAC = 3'h0;
  localparam logic [3:0] RATE_SAT = 4'hA;           // codes above saturate
  localparam logic [3:0] HOLD_SAT = 4'hA;

  // ----------------------------------------
  // step and hold times, ns
  // ----------------------------------------
  localparam int ATK_NORM_NS = 104000;
  localparam int DCY_NORM_NS = 410000;
  localparam int ATK_LIM_NS = 22700;
  localparam int DCY_LIM_NS = 90800;
  localparam int HOLD_NS = 2670000;

  // ----------------------------------------
  // target thresholds, full scale 7FFF
  // ----------------------------------------
  localparam logic [15:0][SAMPLE_W-1:0] TARGET_TBL = '{
    16'h6BB2, 16'h6BB2, 16'h5A9D, 16'h4C3F, 16'h4027, 16'h35FA, 16'h2D6B, 16'h2637,
    16'h2027, 16'h1B0E, 16'h16C3, 16'h1327, 16'h101D, 16'h0D8F, 16'h0B68, 16'h0999};

  // loop state
  typedef enum logic [1:0] {
    LOOP_OFF = 2'b00,
    LOOP_TRACK = 2'b01,
    LOOP_LIMIT = 2'b10
  } loop_e;

  // clip a rate or hold code to its saturation point
  function automatic logic [3:0] sat_code(input logic [3:0] code, input logic [3:0] lim);
    sat_code = (code > lim) ? lim : code;
  endfunction : sat_code

endpackage : level_loop_pkg

/* design/step_timer.sv */
// step timer: free count that pulses once per programmed period
// assumes period is at least one and restart is synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module step_timer #(
  parameter int CNT_W = 32
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic [CNT_W-1:0] period,
  output logic tick
);

  logic [CNT_W-1:0] count; // cycles since last tick

  // ----------------------------------------
  // counter and tick
  // ----------------------------------------
  // compare with >= so a period shortened mid-count ends promptly
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= period - CNT_W'(1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + CNT_W'(1);
      tick <= 1'b0;
    end
  end

endmodule : step_timer
`default_nettype wire

/* tb/amp_model.sv */
// amplifier and peak path model: feeds the level loop a sample stream
// assumes the bench sets level and sign_hold; samples leave on the falling edge
`timescale 1ns/100ps
`default_nettype none
module amp_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [level_loop_pkg::GAIN_W-1:0] amp_gain,
  input wire logic [15:0] level,
  input wire logic sign_hold,
  output var level_loop_pkg::sample_s sample
);
  import level_loop_pkg::*;

  // ----------------------------------------
  // amplified level
  // ----------------------------------------
  logic neg; // sign of the next sample
  logic [SAMPLE_W-1:0] mag; // magnitude after the amplifier
  // gain adds a small offset so the loop sees its own effect on the signal
  assign mag = level + {6'h00, amp_gain, 4'h0};

  // ----------------------------------------
  // sample stream
  // ----------------------------------------
  // one sample every second cycle, sign alternating unless held
  always @(negedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample <= '0;
      neg <= 1'b0;
    end else if (!sample.valid) begin
      sample.valid <= 1'b1;
      sample.data <= neg ? -mag : mag;
      neg <= neg ^ !sign_hold; // held sign starves the zero-cross gate
    end else begin
      sample.valid <= 1'b0;
      sample.data <= ~sample.data; // data carries no meaning between strobes
    end
  end
endmodule : amp_model
`default_nettype wire

/* tb/input_auto_level_control_tb.sv */
// level loop testbench: registers, rise, fall, limits, hold-off, limiter, zero cross
// assumes shortened step parameters and the amplifier model beside the design
`timescale 1ns/100ps
`default_nettype none
module input_auto_level_control_tb;
  import level_loop_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk; // 100 MHz
  logic arst_n; // async reset
  reg_wr_s reg_wr; // register write port
  logic [ADDR_W-1:0] rd_addr; // read index
  logic [REG_W-1:0] reg_rdata; // read data
  sample_s sample; // model to design
  logic manual_gain_load; // manual volume strobe
  logic [GAIN_W-1:0] manual_input_gain; // manual volume
  logic [GAIN_W-1:0] amp_gain; // gain to amplifier
  logic gain_step; // step applied
  logic loop_active; // loop running
  logic [15:0] level; // model input level
  logic sign_hold; // freeze sample sign
  int errors; // mismatches
  int total_checks; // comparisons

  // short step counts keep the run small; decay kept above attack
  level_loop #(.ATK_NORM_CYC(8), .DCY_NORM_CYC(16), .ATK_LIM_CYC(4), .DCY_LIM_CYC(8),
    .HOLD_CYC(32)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr),
    .rd_addr(rd_addr), .reg_rdata(reg_rdata), .sample(sample),
    .manual_gain_load(manual_gain_load), .manual_input_gain(manual_input_gain),
    .amp_gain(amp_gain), .gain_step(gain_step), .loop_active(loop_active));

  amp_model partner (.sys_clk(sys_clk), .arst_n(arst_n), .amp_gain(amp_gain),
    .level(level), .sign_hold(sign_hold), .sample(sample));

  // ----------------------------------------
  // helpers, all entered and left on a falling edge
  // ----------------------------------------
  task automatic conclude();
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // one-cycle write strobe; a gap cycle follows so strobes never merge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    reg_wr <= '{1'b1, a, d};
    @(negedge sys_clk);
    reg_wr.wr <= 1'b0;
    @(negedge sys_clk);
  endtask : wr

  // read data lands on the same rising edge that samples the index
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    rd_addr <= a;
    @(negedge sys_clk);
    chk(16'(reg_rdata), 16'(exp), "register readback");
  endtask : rd

  task automatic load(input logic [GAIN_W-1:0] g);
    manual_input_gain <= g;
    manual_gain_load <= 1'b1;
    @(negedge sys_clk);
    manual_gain_load <= 1'b0;
    @(negedge sys_clk);
  endtask : load

  // bounded wait for the next step; n returns the cycles it took
  task automatic wait_step(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (gain_step !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      errors++;
      $display("CHECK FAILED %0t no gain step", $time);
      conclude();
    end
  endtask : wait_step

  // first two intervals after a change may be short, so they are skipped
  task automatic gap(input int exp);
    int n;
    wait_step(n);
    wait_step(n);
    wait_step(n);
    chk(16'(n), 16'(exp), "step spacing");
  endtask : gap

  // wait for a gain, then make sure it stays there
  task automatic settle(input logic [GAIN_W-1:0] g);
    int n;
    n = 0;
    while (amp_gain !== g && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("CHECK FAILED %0t gain never reached %h", $time, g);
      conclude();
    end
    cyc(100);
    chk(16'(amp_gain), 16'(g), "settled gain");
  endtask : settle

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset();
    chk(16'(loop_active), 16'h0000, "loop idle after reset");
    rd(7'h20, 9'h038);
    rd(7'h21, 9'h00B);
    rd(7'h22, 9'h032);
    rd(7'h2A, 9'h000);
    rd(7'h23, 9'h000);
  endtask : s_reset

  // reserved bits drop, unmapped index leaves neighbours alone
  task automatic s_regs();
    wr(7'h20, 9'h0C0);
    rd(7'h20, 9'h000);
    wr(7'h21, 9'h1FF);
    rd(7'h21, 9'h0FF);
    wr(7'h22, 9'h1FF);
    rd(7'h22, 9'h1FF);
    wr(7'h2A, 9'h1FF);
    rd(7'h2A, 9'h002);
    wr(7'h23, 9'h1FF);
    rd(7'h23, 9'h000);
    rd(7'h22, 9'h1FF);
    wr(7'h21, 9'h00B);
    wr(7'h22, 9'h000);
    wr(7'h2A, 9'h000);
  endtask : s_regs

  // quiet input: gain climbs at decay rate up to the ceiling
  task automatic s_rise();
    level <= 16'h0100;
    wr(7'h20, 9'h118);
    cyc(1);
    chk(16'(loop_active), 16'h0001, "loop running");
    gap(16);
    wr(7'h22, 9'h010);
    gap(32);
    settle(6'h1F);
  endtask : s_rise

  // loud input falls at attack rate; top target code turns it round
  task automatic s_fall();
    level <= 16'h5000;
    wr(7'h20, 9'h139);
    gap(8);
    wr(7'h21, 9'h00F);
    gap(32);
    wr(7'h21, 9'h00B);
    settle(6'h08);
    // long hold code: a quiet input must not lift the gain for a while
    wr(7'h21, 9'h0AB);
    level <= 16'h0100;
    cyc(300);
    chk(16'(amp_gain), 16'h0008, "hold delays rise");
  endtask : s_fall

  // off: gain frozen against a quiet input; manual load skips the limits
  task automatic s_disable();
    level <= 16'h0100;
    wr(7'h20, 9'h039);
    wr(7'h21, 9'h00B);
    cyc(300);
    chk(16'(loop_active), 16'h0000, "loop stopped");
    chk(16'(amp_gain), 16'h0008, "gain frozen");
    wr(7'h20, 9'h000);
    load(6'h3F);
    chk(16'(amp_gain), 16'h003F, "manual gain unclamped");
    // enabled again, the same high gain is pulled down to the ceiling
    wr(7'h20, 9'h118);
    settle(6'h1F);
    wr(7'h20, 9'h000);
  endtask : s_disable

  // limiter never climbs past the gain in force at entry
  task automatic s_limiter();
    load(6'h20);
    wr(7'h22, 9'h100);
    wr(7'h20, 9'h138);
    cyc(300);
    chk(16'(amp_gain), 16'h0020, "limiter holds start gain");
    level <= 16'h5000;
    gap(4);
    cyc(40);
    level <= 16'h0100;
    gap(8);
    settle(6'h20);
  endtask : s_limiter

  // zero-cross gate: no step until the sample sign flips
  task automatic s_zero_cross();
    wr(7'h20, 9'h038);
    wr(7'h22, 9'h000);
    load(6'h10);
    wr(7'h2A, 9'h002);
    sign_hold <= 1'b1;
    level <= 16'h5000;
    cyc(4);
    wr(7'h20, 9'h138);
    cyc(200);
    chk(16'(amp_gain), 16'h0010, "gated step held");
    sign_hold <= 1'b0;
    cyc(40);
    chk({15'h0000, amp_gain < 6'h10}, 16'h0001, "step after crossing");
  endtask : s_zero_cross

  // ----------------------------------------
  // clock and main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    errors = 0;
    total_checks = 0;
    arst_n = 1'b0;
    reg_wr = '0;
    rd_addr = '0;
    manual_gain_load = 1'b0;
    manual_input_gain = '0;
    level = 16'h0100;
    sign_hold = 1'b0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    s_reset();
    s_regs();
    s_rise();
    s_fall();
    s_disable();
    s_limiter();
    s_zero_cross();
    conclude();
  end
endmodule : input_auto_level_control_tb
`default_nettype wire
